// file: verilog/ssp_pkg.sv
`default_nettype none
package ssp_pkg;

	localparam int DATA_W           = 16;
	localparam int FIFO_DEPTH       = 8;
	localparam int SERVICE_LEVEL    = 4;
	localparam int TIMEOUT_CYCLES   = 512;
	localparam int CTRL_WORD_BITS   = 8;
	localparam int CTRL_WAIT_BITS   = 1;
	localparam int MIN_FRAME_BITS   = 4;
	localparam int MAX_FRAME_BITS   = 16;
	localparam int MIN_PRESCALE     = 2;
	localparam int MAX_PRESCALE     = 254;
	localparam int SPH1_TAIL_HALVES = 2;
	localparam int SPH0_TAIL_HALVES = 1;

	typedef enum logic [1:0] {
		FMT_SPI       = 2'b00,
		FMT_PULSED    = 2'b01,
		FMT_CTRL_WORD = 2'b10
	} format_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_XFER  = 2'b10,
		ST_TAIL  = 2'b11
	} state_t;

	// frame_size_m1 holds frame length minus one (3..15)
	typedef struct packed {
		logic       enable;
		logic       master;
		format_t    format;
		logic       clock_polarity_bit;
		logic       clock_phase_bit;
		logic [3:0] frame_size_m1;
		logic [7:0] prescale_divisor;
		logic [7:0] serial_clock_rate_field;
		logic [3:0] interrupt_mask;
	} config_t;

	typedef struct packed {
		logic overrun;
		logic timeout;
		logic rx_service;
		logic tx_service;
	} int_vec_t;

	localparam int_vec_t INT_RESET = 4'h0;

endpackage
`default_nettype wire

// file: verilog/ssp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_b_i,
	// fill side
	input  wire logic               push_i,
	input  wire logic [WIDTH-1:0]   push_data_i,
	// drain side
	input  wire logic               pop_i,
	output logic      [WIDTH-1:0]   head_o,
	// status
	output logic                    full_o,
	output logic                    empty_o,
	output logic [$clog2(DEPTH):0]  count_o
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW-1:0]    rd_ptr_d;
	logic [AW:0]      count_d;
	logic             push_ok;
	logic             pop_ok;

	assign push_ok  = push_i && !full_o;
	assign pop_ok   = pop_i && !empty_o;
	assign rd_ptr_d = rd_ptr_q + AW'(pop_ok);
	assign count_d  = count_o + (AW+1)'(push_ok) - (AW+1)'(pop_ok);

	always_ff @(posedge clock_i) begin
		if (push_ok)
			mem_q[wr_ptr_q] <= push_data_i;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_o  <= '0;
			full_o   <= 1'b0;
			empty_o  <= 1'b1;
			head_o   <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push_ok);
			rd_ptr_q <= rd_ptr_d;
			count_o  <= count_d;
			full_o   <= count_d == (AW+1)'(DEPTH);
			empty_o  <= count_d == '0;
			// show-ahead head register, bypassing a write into the next head slot
			head_o   <= (push_ok && wr_ptr_q == rd_ptr_d) ? push_data_i : mem_q[rd_ptr_d];
		end
	end

endmodule // ssp_fifo
`default_nettype wire

// file: verilog/sync_serial_port_core.sv
// Function
// - first divider stage divides system clock by even prescale 2..254.
// - second stage divides by one plus rate field, 1..256.
// - data written goes into 16-bit, 8-entry transmit fifo until shifted.
// - received words enter 16-bit, 8-entry receive fifo; reads pop oldest.
// - four interrupt sources are ORed into one request line.
// - a source reaches the request only when its mask bit is one.
// - raw and masked state of every source are readable.
// - frames are 4..16 bits, shifted most significant bit first.
// - serial clock idles inactive, toggles only during transfers.
// - timeout raised when clock idles while receive fifo holds data.
// - spi and control-word frame select is active low for whole frame.
// - pulsed format idles low, tx tristated; select pulses high one period.
// - pulsed format drives on rising, samples on falling, msb first.
// - pulsed format stores received word at the falling edge that samples lsb.
// - control-word: 8-bit message out, one clock wait, 4..16 bits back.
// - spi polarity bit picks steady low or high idle clock.
// - spi phase bit picks capture on first or second transition.
// - spi 0/0 idle: clock low, select high, data low; pad by role.
// - select low, data half period later, clock rises half period after.
// - spi 0/0 samples on rising edges, changes data on falling edges.
// - select returns high one period after last bit sampled.
// - phase 0 back-to-back pulses select high; slave frozen while selected.
`timescale 1ns/100ps
`default_nettype none
module sync_serial_port_core #(
	parameter int FIFO_DEPTH     = ssp_pkg::FIFO_DEPTH,
	parameter int TIMEOUT_CYCLES = ssp_pkg::TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic                      clock_i,
	input  wire logic                      rst_b_i,
	// configuration and interrupt control
	input  wire ssp_pkg::config_t          cfg_i,
	input  wire logic                      overrun_clear_i,
	// data register, write side
	input  wire logic                      tx_write_i,
	input  wire logic [ssp_pkg::DATA_W-1:0] tx_data_i,
	output logic                           tx_ready_o,
	// data register, read side
	input  wire logic                      rx_read_i,
	output logic [ssp_pkg::DATA_W-1:0]     rx_data_o,
	output logic                           rx_valid_o,
	// status
	output ssp_pkg::int_vec_t              raw_int_o,
	output ssp_pkg::int_vec_t              masked_int_o,
	output logic                           irq_o,
	output logic                           busy_o,
	// serial pins
	input  wire logic                      serial_clock_pin_i,
	output logic                           serial_clock_pin_o,
	output logic                           serial_clock_oe_o,
	input  wire logic                      frame_select_pin_i,
	output logic                           frame_select_pin_o,
	output logic                           frame_select_oe_o,
	output logic                           serial_out_pin_o,
	output logic                           serial_out_oe_o,
	input  wire logic                      serial_in_pin_i
);
	localparam int DW  = ssp_pkg::DATA_W;
	localparam int CW  = $clog2(FIFO_DEPTH) + 1;
	localparam int TOW = $clog2(TIMEOUT_CYCLES + 1);

	if (FIFO_DEPTH < ssp_pkg::SERVICE_LEVEL || TIMEOUT_CYCLES < 1) begin : g_bad_param
		$error("fifo depth below service level or zero timeout");
	end

	// input synchronisers: bit 0 clock, bit 1 frame select, bit 2 data in
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] pins_in;
	assign pins_in = {serial_in_pin_i, frame_select_pin_i, serial_clock_pin_i};
	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clock_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				meta_q[i] <= i == 1;
				sync_q[i] <= i == 1;
			end else begin
				meta_q[i] <= pins_in[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	// fifos
	logic [DW-1:0] tx_head;
	logic          tx_empty;
	logic          tx_full;
	logic [CW-1:0] tx_count;
	logic          rx_full;
	logic          rx_empty;
	logic [CW-1:0] rx_count;
	logic          do_load;
	logic          do_push;
	logic [DW-1:0] rx_sr_q;
	logic [DW-1:0] rx_word;

	ssp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clock_i     (clock_i),
		.rst_b_i     (rst_b_i),
		.push_i      (tx_write_i),
		.push_data_i (tx_data_i),
		.pop_i       (do_load),
		.head_o      (tx_head),
		.full_o      (tx_full),
		.empty_o     (tx_empty),
		.count_o     (tx_count)
	);

	ssp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clock_i     (clock_i),
		.rst_b_i     (rst_b_i),
		.push_i      (do_push),
		.push_data_i (rx_word),
		.pop_i       (rx_read_i),
		.head_o      (rx_data_o),
		.full_o      (rx_full),
		.empty_o     (rx_empty),
		.count_o     (rx_count)
	);

	// format decode
	logic       is_ti;
	logic       is_mw;
	logic       late;
	logic       cpol;
	logic [4:0] frame_n;
	logic [4:0] bits_total;
	assign is_ti      = cfg_i.format == ssp_pkg::FMT_PULSED;
	assign is_mw      = cfg_i.format == ssp_pkg::FMT_CTRL_WORD;
	assign late       = is_ti || (!is_mw && cfg_i.clock_phase_bit);
	assign cpol       = !is_ti && !is_mw && cfg_i.clock_polarity_bit;
	assign frame_n    = 5'(cfg_i.frame_size_m1) + 5'h01;
	assign bits_total = is_ti ? frame_n + 5'h01 :
		is_mw ? frame_n + 5'(ssp_pkg::CTRL_WORD_BITS + ssp_pkg::CTRL_WAIT_BITS) : frame_n;

	// bit-rate divider, runs only while the master is framing
	ssp_pkg::state_t state_q;
	ssp_pkg::state_t state_d;
	logic [6:0] pre_cnt_q;
	logic [7:0] rate_cnt_q;
	logic [6:0] pre_lim;
	logic       pre_wrap;
	logic       tick;
	assign pre_lim  = (cfg_i.prescale_divisor[7:1] == 7'h00) ? 7'h00 : cfg_i.prescale_divisor[7:1] - 7'h01;
	assign pre_wrap = pre_cnt_q == pre_lim;
	assign tick     = pre_wrap && rate_cnt_q == cfg_i.serial_clock_rate_field;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_cnt_q  <= 7'h00;
			rate_cnt_q <= 8'h00;
		end else if (state_q == ssp_pkg::ST_IDLE) begin
			pre_cnt_q  <= 7'h00;
			rate_cnt_q <= 8'h00;
		end else begin
			pre_cnt_q  <= pre_wrap ? 7'h00 : pre_cnt_q + 7'h01;
			if (pre_wrap)
				rate_cnt_q <= tick ? 8'h00 : rate_cnt_q + 8'h01;
		end
	end

	// master sequencing
	logic [5:0] edge_q;
	logic [5:0] edge_d;
	logic [1:0] tail_q;
	logic [1:0] tail_d;
	logic [4:0] bit_idx;
	logic       leading;
	logic       edge_now;
	logic       last_edge;
	logic       tx_ok;
	logic       tx_next_ok;
	logic       rx_ok;
	logic       more;
	logic       m_shift;
	logic       m_sample;
	logic       m_load;
	logic       m_push;
	logic       fss_q;
	logic       fss_d;
	logic       master_run;
	assign master_run = cfg_i.enable && cfg_i.master;
	assign bit_idx    = edge_q[5:1];
	assign leading    = !edge_q[0];
	assign last_edge  = edge_q == {bits_total, 1'b0} - 6'h01;
	assign tx_ok      = is_mw ? bit_idx < 5'(ssp_pkg::CTRL_WORD_BITS) : !(is_ti && bit_idx == 5'h00);
	assign tx_next_ok = is_mw ? bit_idx < 5'(ssp_pkg::CTRL_WORD_BITS - 1) : bit_idx < bits_total - 5'h01;
	assign rx_ok      = is_mw ? bit_idx >= 5'(ssp_pkg::CTRL_WORD_BITS + ssp_pkg::CTRL_WAIT_BITS) : tx_ok;
	assign more       = master_run && !tx_empty;
	assign edge_now   = tick && (state_q == ssp_pkg::ST_XFER || (state_q == ssp_pkg::ST_SETUP && late));

	always_comb begin
		state_d  = state_q;
		edge_d   = edge_q;
		tail_d   = tail_q;
		fss_d    = fss_q;
		m_shift  = 1'b0;
		m_sample = 1'b0;
		m_load   = 1'b0;
		m_push   = 1'b0;
		case (state_q)
			ssp_pkg::ST_IDLE: begin
				fss_d  = !is_ti;
				edge_d = 6'h00;
				if (more) begin
					m_load  = 1'b1;
					state_d = is_ti ? ssp_pkg::ST_XFER : ssp_pkg::ST_SETUP;
					fss_d   = 1'b0;
				end
			end
			ssp_pkg::ST_SETUP: begin
				if (tick && !late) begin
					m_shift = 1'b1;
					state_d = ssp_pkg::ST_XFER;
				end
			end
			ssp_pkg::ST_XFER, ssp_pkg::ST_TAIL: begin
				if (state_q == ssp_pkg::ST_TAIL && tick) begin
					if (tail_q == 2'h1) begin
						state_d = ssp_pkg::ST_IDLE;
						fss_d   = !is_ti;
					end
					tail_d = tail_q - 2'h1;
				end
			end
			default: state_d = ssp_pkg::ST_IDLE;
		endcase
		if (edge_now) begin
			state_d = ssp_pkg::ST_XFER;
			edge_d  = edge_q + 6'h01;
			if (is_ti)
				fss_d = edge_q < 6'h02;
			if (late) begin
				m_shift  = leading && tx_ok;
				m_sample = !leading && rx_ok;
			end else begin
				m_sample = leading && rx_ok;
				m_shift  = !leading && tx_next_ok;
			end
			if (last_edge) begin
				m_push = 1'b1;
				edge_d = 6'h00;
				if (late && more) begin
					m_load = 1'b1;
				end else if (is_ti) begin
					state_d = ssp_pkg::ST_IDLE;
				end else begin
					state_d = ssp_pkg::ST_TAIL;
					tail_d  = late ? 2'(ssp_pkg::SPH1_TAIL_HALVES) : 2'(ssp_pkg::SPH0_TAIL_HALVES);
				end
			end
		end
		if (!master_run && state_q != ssp_pkg::ST_IDLE && state_q != ssp_pkg::ST_TAIL && !cfg_i.master)
			state_d = ssp_pkg::ST_IDLE;
	end

	// slave edge detection on the synchronised pins
	logic       sclk_prev_q;
	logic       fss_prev_q;
	logic       rise;
	logic       fall;
	logic       s_lead;
	logic       s_trail;
	logic       armed_q;
	logic [4:0] s_cnt_q;
	logic       s_run;
	logic       s_shift;
	logic       s_sample;
	logic       s_load;
	logic       s_push;
	assign s_run   = cfg_i.enable && !cfg_i.master && !is_mw;
	assign rise    = sync_q[0] && !sclk_prev_q;
	assign fall    = !sync_q[0] && sclk_prev_q;
	assign s_lead  = cpol ? fall : rise;
	assign s_trail = cpol ? rise : fall;

	always_comb begin
		s_shift  = 1'b0;
		s_sample = 1'b0;
		s_load   = 1'b0;
		s_push   = 1'b0;
		if (s_run && armed_q) begin
			if (late) begin
				s_load   = s_lead && s_cnt_q == 5'h00;
				s_shift  = s_lead;
				s_sample = s_trail;
			end else begin
				s_sample = s_lead;
				s_shift  = s_trail && s_cnt_q != frame_n;
			end
			s_push = s_sample && s_cnt_q == frame_n - 5'h01;
		end
		// phase 0 slave loads only on select falling; frozen while selected
		if (s_run && !is_ti && !late && !sync_q[1] && fss_prev_q) begin
			s_load  = 1'b1;
			s_shift = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sclk_prev_q <= 1'b0;
			fss_prev_q  <= 1'b1;
			armed_q     <= 1'b0;
			s_cnt_q     <= 5'h00;
		end else begin
			sclk_prev_q <= sync_q[0];
			fss_prev_q  <= sync_q[1];
			if (!s_run) begin
				armed_q <= 1'b0;
				s_cnt_q <= 5'h00;
			end else if (is_ti) begin
				if (fall && sync_q[1]) begin
					armed_q <= 1'b1;
					s_cnt_q <= 5'h00;
				end else if (s_push) begin
					armed_q <= 1'b0;
				end else if (s_sample) begin
					s_cnt_q <= s_cnt_q + 5'h01;
				end
			end else begin
				armed_q <= !sync_q[1];
				if (sync_q[1] || s_push)
					s_cnt_q <= 5'h00;
				else if (s_sample)
					s_cnt_q <= s_cnt_q + 5'h01;
			end
		end
	end

	// shared shift path
	logic          do_shift;
	logic          do_sample;
	logic [DW-1:0] tx_sr_q;
	logic [DW-1:0] load_word;
	logic [1:0]    m_sample_q;
	logic [2:0]    m_push_q;
	logic          s_push_q;
	assign do_load   = (m_load || s_load) && !tx_empty;
	assign do_shift  = m_shift || s_shift;
	// master capture waits out the input synchroniser; push follows the last capture
	assign do_sample = m_sample_q[1] || s_sample;
	assign do_push   = m_push_q[2] || s_push_q;
	assign rx_word   = rx_sr_q & ({DW{1'b1}} >> (5'h10 - frame_n));
	assign load_word = is_mw ? {tx_head[7:0], 8'h00} : tx_head << (5'h10 - frame_n);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_sr_q          <= '0;
			rx_sr_q          <= '0;
			serial_out_pin_o <= 1'b0;
			m_sample_q       <= 2'h0;
			m_push_q         <= 3'h0;
			s_push_q         <= 1'b0;
		end else begin
			m_sample_q       <= {m_sample_q[0], m_sample};
			m_push_q         <= {m_push_q[1:0], m_push};
			s_push_q         <= s_push;
			if (m_load || s_load)
				tx_sr_q <= do_load ? load_word : '0;
			else if (do_shift)
				tx_sr_q <= {tx_sr_q[DW-2:0], 1'b0};
			if (do_shift)
				serial_out_pin_o <= (m_load || s_load) ? load_word[DW-1] : tx_sr_q[DW-1];
			else if (state_q == ssp_pkg::ST_IDLE && !armed_q)
				serial_out_pin_o <= 1'b0;
			if (do_sample)
				rx_sr_q <= {rx_sr_q[DW-2:0], sync_q[2]};
			else if (s_load)
				rx_sr_q <= '0;
		end
	end

	// master pin drive
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q            <= ssp_pkg::ST_IDLE;
			edge_q             <= 6'h00;
			tail_q             <= 2'h0;
			fss_q              <= 1'b1;
			serial_clock_pin_o <= 1'b0;
		end else begin
			state_q <= state_d;
			edge_q  <= edge_d;
			tail_q  <= tail_d;
			fss_q   <= fss_d;
			if (edge_now)
				serial_clock_pin_o <= !serial_clock_pin_o;
			else if (state_q == ssp_pkg::ST_IDLE || state_q == ssp_pkg::ST_TAIL)
				serial_clock_pin_o <= cpol;
		end
	end
	assign frame_select_pin_o = fss_q;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serial_clock_oe_o <= 1'b0;
			frame_select_oe_o <= 1'b0;
			serial_out_oe_o   <= 1'b0;
			busy_o            <= 1'b0;
		end else begin
			serial_clock_oe_o <= cfg_i.master;
			frame_select_oe_o <= cfg_i.master;
			serial_out_oe_o   <= cfg_i.master ? !(is_ti && state_d == ssp_pkg::ST_IDLE) : armed_q;
			busy_o            <= state_d != ssp_pkg::ST_IDLE || armed_q;
		end
	end

	// receive timeout and interrupt status
	logic [TOW-1:0]    to_cnt_q;
	logic              overrun_q;
	ssp_pkg::int_vec_t raw;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			to_cnt_q  <= '0;
			overrun_q <= 1'b0;
		end else begin
			if (rx_empty || rx_read_i || do_sample || do_shift || state_q != ssp_pkg::ST_IDLE)
				to_cnt_q <= '0;
			else if (to_cnt_q != TOW'(TIMEOUT_CYCLES))
				to_cnt_q <= to_cnt_q + TOW'(1);
			if (do_push && rx_full)
				overrun_q <= 1'b1;
			else if (overrun_clear_i)
				overrun_q <= 1'b0;
		end
	end

	assign raw.tx_service = tx_count <= CW'(ssp_pkg::SERVICE_LEVEL);
	assign raw.rx_service = rx_count >= CW'(ssp_pkg::SERVICE_LEVEL);
	assign raw.timeout    = to_cnt_q == TOW'(TIMEOUT_CYCLES);
	assign raw.overrun    = overrun_q;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			raw_int_o    <= ssp_pkg::INT_RESET;
			masked_int_o <= ssp_pkg::INT_RESET;
			irq_o        <= 1'b0;
			tx_ready_o   <= 1'b0;
			rx_valid_o   <= 1'b0;
		end else begin
			raw_int_o    <= raw;
			masked_int_o <= raw & cfg_i.interrupt_mask;
			irq_o        <= |(raw & cfg_i.interrupt_mask);
			tx_ready_o   <= !tx_full;
			rx_valid_o   <= !rx_empty;
		end
	end

endmodule // sync_serial_port_core
`default_nettype wire

// file: bench/ssp_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_checker #(
	parameter int TIMEOUT_CYCLES = 8
) (
	// observed top-level ports
	input wire logic              clock_i,
	input wire logic              rst_b_i,
	input wire ssp_pkg::config_t  cfg_i,
	input wire logic              overrun_clear_i,
	input wire logic              rx_read_i,
	input wire logic              rx_valid_o,
	input wire ssp_pkg::int_vec_t raw_int_o,
	input wire ssp_pkg::int_vec_t masked_int_o,
	input wire logic              irq_o,
	input wire logic              busy_o,
	input wire logic              serial_clock_pin_o,
	input wire logic              serial_clock_oe_o,
	input wire logic              frame_select_pin_o,
	input wire logic              serial_out_pin_o,
	input wire logic              serial_out_oe_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	logic        spi_like;
	logic [15:0] idle_q;
	assign spi_like = cfg_i.format != ssp_pkg::FMT_PULSED;
	// idle master cycles with unread receive data
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			idle_q <= 16'h0000;
		else if (busy_o || !rx_valid_o || rx_read_i || !cfg_i.master)
			idle_q <= 16'h0000;
		else if (idle_q != 16'hffff)
			idle_q <= idle_q + 16'h0001;
	end
	sequence s_quiet;
		(cfg_i.master && !busy_o && $stable(cfg_i)) [*3];
	endsequence
	a_irq_from_masked: assert property ((masked_int_o != 4'h0) [*2] |-> irq_o)
		else $error("irq low while a masked source is set");
	a_mask_gates_source: assert property (
		$stable(raw_int_o) && $stable(cfg_i.interrupt_mask) |-> masked_int_o == (raw_int_o & cfg_i.interrupt_mask))
		else $error("masked status differs from raw and mask");
	a_idle_clock_level: assert property (
		s_quiet |-> serial_clock_pin_o == (cfg_i.format == ssp_pkg::FMT_SPI && cfg_i.clock_polarity_bit))
		else $error("serial clock not at its idle level");
	a_idle_select_level: assert property (s_quiet |-> frame_select_pin_o == spi_like)
		else $error("frame select not at its idle level");
	a_idle_data_line: assert property (
		s_quiet |-> (spi_like ? !serial_out_pin_o : !serial_out_oe_o))
		else $error("serial out not idle");
	a_clock_pad_role: assert property (
		$past(rst_b_i) && $stable(cfg_i.master) |-> serial_clock_oe_o == cfg_i.master)
		else $error("clock pad enable does not follow role");
	a_select_during_clock: assert property (
		cfg_i.master && spi_like && busy_o && $changed(serial_clock_pin_o) |-> !frame_select_pin_o)
		else $error("serial clock moved with frame select high");
	a_rx_service_valid: assert property (raw_int_o.rx_service |-> rx_valid_o)
		else $error("receive service set with empty fifo");
	a_overrun_sticky: assert property (raw_int_o.overrun && !$past(overrun_clear_i) |=> raw_int_o.overrun)
		else $error("overrun dropped without clear");
	a_timeout_raised: assert property (int'(idle_q) > TIMEOUT_CYCLES + 4 |-> raw_int_o.timeout)
		else $error("timeout missing after idle with data");
	c_overrun: cover property (raw_int_o.overrun && irq_o);
	c_timeout: cover property ($rose(raw_int_o.timeout));
	c_pulsed_frame: cover property (!spi_like && $rose(frame_select_pin_o));
endmodule // ssp_checker
`default_nettype wire

// file: bench/ssp_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
	// serial side
	input  wire logic        sclk_i,
	input  wire logic        fss_i,
	input  wire logic        mosi_i,
	output var  logic        miso_o,
	// bench side
	input  wire logic        pulsed_i,
	input  wire logic [3:0]  size_m1_i,
	input  wire logic [15:0] word_i,
	output var  logic [15:0] got_o,
	output var  int          frames_o
);
	logic [15:0] sh;
	int          n;
	initial begin
		miso_o = 1'b0;
		got_o = 16'h0000;
		frames_o = 0;
		n = 0;
	end
	// msb goes out as soon as select falls
	always @(negedge fss_i) begin
		if (!pulsed_i) begin
			sh = word_i;
			n = size_m1_i + 1;
			got_o = 16'h0000;
			miso_o = word_i[size_m1_i];
		end
	end
	// a released line shows the inverse of its last bit
	always @(posedge fss_i) begin
		if (!pulsed_i)
			miso_o = ~miso_o;
	end
	always @(posedge sclk_i) begin
		if (pulsed_i)
			miso_o = n > 0 ? sh[n-1] : ~miso_o;
		else if (!fss_i && n > 0) begin
			got_o = {got_o[14:0], mosi_i};
			n--;
			if (n == 0)
				frames_o++;
		end
	end
	always @(negedge sclk_i) begin
		if (!pulsed_i) begin
			if (!fss_i && n > 0)
				miso_o = sh[n-1];
		end else begin
			if (n > 0) begin
				got_o = {got_o[14:0], mosi_i};
				n--;
				if (n == 0)
					frames_o++;
			end
			// select pulse arms the next word
			if (fss_i) begin
				sh = word_i;
				n = size_m1_i + 1;
				got_o = 16'h0000;
			end
		end
	end
endmodule // ssp_peer
`default_nettype wire

// file: bench/sync_serial_port_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module sync_serial_port_core_test;
	logic              clock_i;
	logic              rst_b_i;
	ssp_pkg::config_t  cfg;
	ssp_pkg::int_vec_t raw, masked;
	logic              ovr_clr, tx_write, rx_read, tx_ready, rx_valid, irq, busy;
	logic              sclk_o, sclk_oe, fss_o, fss_oe, sdo, sdo_oe, miso;
	logic [15:0]       tx_data, rx_data, peer_word, peer_got;
	logic [15:0]       q[$];
	logic [31:0]       seed;
	wire logic         sclk_w, fss_w;
	int                failures = 0;
	int                samples_checked = 0;
	int                frames, fss_rises, per, k, p, t;
	int                cp[3] = '{254, 2, 1};
	int                cr[3] = '{0, 255, 0};
	time               t_last = 0;
	assign sclk_w = sclk_oe ? sclk_o : 1'b0;
	assign fss_w = fss_oe ? fss_o : 1'b1;
	sync_serial_port_core #(.FIFO_DEPTH(8), .TIMEOUT_CYCLES(8)) dut_u (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .overrun_clear_i(ovr_clr),
		.tx_write_i(tx_write), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_read_i(rx_read),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .raw_int_o(raw), .masked_int_o(masked), .irq_o(irq),
		.busy_o(busy), .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o), .serial_clock_oe_o(sclk_oe),
		.frame_select_pin_i(fss_w), .frame_select_pin_o(fss_o), .frame_select_oe_o(fss_oe),
		.serial_out_pin_o(sdo), .serial_out_oe_o(sdo_oe), .serial_in_pin_i(miso));
	ssp_peer peer_u (.sclk_i(sclk_w), .fss_i(fss_w), .mosi_i(sdo), .miso_o(miso),
		.pulsed_i(cfg.format == ssp_pkg::FMT_PULSED), .size_m1_i(cfg.frame_size_m1), .word_i(peer_word),
		.got_o(peer_got), .frames_o(frames));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge sclk_w) begin
		per = int'(($time - t_last) / 5);
		t_last = $time;
	end
	always @(posedge fss_w) fss_rises++;
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], ^(seed & 32'h80200003)};
		return seed;
	endfunction
	function automatic logic [15:0] mask(input logic [3:0] m);
		return 16'hffff >> (15 - m);
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic put(input logic [15:0] w);
		tx_data = w;
		tx_write = 1'b1;
		@(negedge clock_i);
		tx_write = 1'b0;
		@(negedge clock_i);
	endtask
	task automatic get(input logic [15:0] exp);
		int n;
		n = 0;
		while (rx_valid !== 1'b1 && n < 100) begin
			@(negedge clock_i);
			n++;
		end
		check("rx_valid", rx_valid, 1);
		check("rx_data", rx_data, exp);
		rx_read = 1'b1;
		@(negedge clock_i);
		rx_read = 1'b0;
		@(negedge clock_i);
	endtask
	task automatic wait_done(input int target);
		int n;
		n = 0;
		while ((frames < target || busy !== 1'b0) && n < 20000) begin
			@(negedge clock_i);
			n++;
		end
		check("frame_done", n < 20000, 1);
		repeat (4) @(negedge clock_i);
	endtask
	initial begin
		#400000;
		failures++;
		complete_run();
	end
	initial begin
		seed = 32'h58d8;
		rst_b_i = 1'b0;
		cfg = '0;
		{ovr_clr, tx_write, rx_read, tx_data, peer_word} = '0;
		cfg.enable = 1'b1;
		cfg.master = 1'b1;
		cfg.prescale_divisor = 8'h02;
		repeat (20) @(negedge clock_i);
		rst_b_i = 1'b1;
		repeat (2) @(negedge clock_i);
		check("tx_ready", tx_ready, 1);
		check("raw_int", raw, 4'h1);
		check("irq", irq, 0);
		for (int f = 0; f < 6; f++) begin
			cfg.format = ssp_pkg::format_t'(2'(f / 2));
			cfg.clock_polarity_bit = f[0];
			repeat (4) @(negedge clock_i);
			check("idle_clock", sclk_o, f == 1);
			check("idle_select", fss_o, f / 2 != 1);
			check("idle_data", f / 2 == 1 ? sdo_oe : sdo, 0);
		end
		cfg.master = 1'b0;
		repeat (4) @(negedge clock_i);
		check("clock_pad", sclk_oe, 0);
		cfg.master = 1'b1;
		cfg.clock_polarity_bit = 1'b0;
		for (int it = 0; it < 14; it++) begin
			p = it < 3 ? cp[it] : int'(rnd() % 10);
			cfg.prescale_divisor = 8'(p);
			cfg.serial_clock_rate_field = it < 3 ? 8'(cr[it]) : 8'(rnd() % 4);
			cfg.frame_size_m1 = it == 2 ? 4'hf : it < 2 ? 4'h3 : 4'(3 + rnd() % 13);
			cfg.format = rnd() % 2 ? ssp_pkg::FMT_PULSED : ssp_pkg::FMT_SPI;
			peer_word = 16'(rnd());
			k = 1 + int'(rnd() % 3);
			p = (p & 254) == 0 ? 2 : p & 254;
			repeat (4) @(negedge clock_i);
			fss_rises = 0;
			t = frames;
			q.delete();
			repeat (k) begin
				q.push_back(16'(rnd()));
				put(q[$]);
			end
			wait_done(t + k);
			check("sclk_period", per, p * (cfg.serial_clock_rate_field + 1));
			check("select_rises", fss_rises, k);
			check("peer_rx", peer_got, q[$] & mask(cfg.frame_size_m1));
			repeat (k) get(peer_word & mask(cfg.frame_size_m1));
		end
		cfg.enable = 1'b0;
		cfg.format = ssp_pkg::FMT_SPI;
		cfg.prescale_divisor = 8'h02;
		cfg.serial_clock_rate_field = 8'h00;
		cfg.frame_size_m1 = 4'h7;
		cfg.interrupt_mask = 4'h8;
		repeat (8) put(16'(rnd()));
		check("tx_full", tx_ready, 0);
		put(16'h00a5);
		t = frames;
		cfg.enable = 1'b1;
		wait_done(t + 8);
		put(16'h005a);
		wait_done(t + 9);
		repeat (12) @(negedge clock_i);
		check("frames", frames, t + 9);
		check("raw_int", raw, 4'hf);
		check("irq", irq, 1);
		check("masked_int", masked, 4'h8);
		cfg.interrupt_mask = 4'h0;
		ovr_clr = 1'b1;
		@(negedge clock_i);
		ovr_clr = 1'b0;
		repeat (2) @(negedge clock_i);
		check("irq_masked", irq, 0);
		check("overrun_clear", raw.overrun, 0);
		repeat (8) get(peer_word & 16'h00ff);
		check("rx_empty", rx_valid, 0);
		complete_run();
	end
endmodule // sync_serial_port_core_test
bind sync_serial_port_core ssp_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .overrun_clear_i(overrun_clear_i),
	.rx_read_i(rx_read_i), .rx_valid_o(rx_valid_o), .raw_int_o(raw_int_o), .masked_int_o(masked_int_o),
	.irq_o(irq_o), .busy_o(busy_o), .serial_clock_pin_o(serial_clock_pin_o),
	.serial_clock_oe_o(serial_clock_oe_o), .frame_select_pin_o(frame_select_pin_o),
	.serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o));
`default_nettype wire
